//--- core/scr_command_regs.v
// Command-mode register bank of one sensor channel with start-up checksum check
//
// Overview of operation
// - Key 16F4h via 94h in window enters command mode
// - Bit 15 shows diagnostic condition, ignores override
// - Write-only bit 14 forces diagnostics off, resets 0
// - Read-only bit 12 flags low supply
// - Bit 11 charge pump clock, writable in command mode without permit
// - Bit 8 sticky corrected error, per readout
// - Bit 7 sticky uncorrectable error, per readout
// - Bit 6 sticky field loss, diag if enabled
// - Bit 4 checksum mismatch, evaluated each start-up
// - Write-only permit bit 11 at 96h, resets 0
// - Checksum polynomial 0x107, 8-bit remainder
// - Checksum starts at FFh
// - Words fed MSB first, shifted into LSB
// - XOR polynomial when remainder bit 8 set
// - Stored checksum byte taken as zero
// - Recompute with stored byte gives zero
// - Checksum covers words 8h to Fh ascending
// - Only power-on reset leaves command mode
// - Command byte: region, address, direction bits
`timescale 1ns/1ps
`include "scr_defines.vh"

module scr_command_regs #(
  parameter ENTRY_WINDOW_CYCLES = `SCR_ENTRY_WINDOW_CYC
) (
  // Clock and reset
  input  wire         clk,
  input  wire         reset_n,
  // Decoded commands from the link framer
  input  wire         cmdValid,
  input  wire [7:0]   cmdByte,
  input  wire [15:0]  cmdData,
  output wire         rdValid,
  output wire [15:0]  rdData,
  // Condition inputs from analog monitors
  input  wire         lowSupplyIn,
  input  wire         fieldLostIn,
  input  wire         fieldLossDetEnable,
  // Memory readout events
  input  wire         memReadDone,
  input  wire         eccCorrected,
  input  wire         eccFatal,
  // Configuration words 8h..Fh, word 8h in the low bits
  input  wire [127:0] cfgWords,
  // Mode and control outputs
  output wire         cmdModeActive,
  output wire         diagModeActive,
  output wire         chargePumpClockOn,
  output wire         programPermit,
  output wire         crcCheckDone,
  output wire [7:0]   crcValue
);

  localparam [3:0] ST_INIT = 4'b0001;
  localparam [3:0] ST_FEED = 4'b0010;
  localparam [3:0] ST_WAIT = 4'b0100;
  localparam [3:0] ST_DONE = 4'b1000;

  // Reset release synchroniser
  reg         rstMeta_r;
  reg         rstSync_r;
  wire        rstN;

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rstMeta_r <= 1'b0;
      rstSync_r <= 1'b0;
    end else begin
      rstMeta_r <= 1'b1;
      rstSync_r <= rstMeta_r;
    end
  end

  assign rstN = rstSync_r;

  // Two-stage synchronisers for the asynchronous monitor levels
  wire [1:0]  condAsync;
  wire [1:0]  condSync;

  assign condAsync = {fieldLostIn, lowSupplyIn};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : gSync
      reg meta_r;
      reg sync_r;
      always @(posedge clk or negedge rstN) begin
        if (!rstN) begin
          meta_r <= 1'b0;
          sync_r <= 1'b0;
        end else begin
          meta_r <= condAsync[gi];
          sync_r <= meta_r;
        end
      end
      assign condSync[gi] = sync_r;
    end
  endgenerate

  // Entry window after power-on reset
  reg  [31:0] winCnt_r;
  wire        windowOpen;

  assign windowOpen = (winCnt_r < ENTRY_WINDOW_CYCLES);

  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      winCnt_r <= 32'h00000000;
    end else if (windowOpen) begin
      winCnt_r <= winCnt_r + 32'h00000001;
    end
  end

  // Command byte decode
  wire [2:0]  cmdRegion;
  wire [3:0]  cmdAddr;
  wire        cmdIsRead;
  wire        regRegion;

  assign cmdRegion = cmdByte[`SCR_CMD_REGION_HI:`SCR_CMD_REGION_LO];
  assign cmdAddr   = cmdByte[`SCR_CMD_ADDR_HI:`SCR_CMD_ADDR_LO];
  assign cmdIsRead = (cmdByte[`SCR_CMD_DIR_BIT] == `SCR_DIR_READ);
  assign regRegion = (cmdRegion == `SCR_REGION_REG);

  // Sticky status flags and control bits
  reg         cmdMode_r;
  reg         diagOverride_r;
  reg         cpClock_r;
  reg         permit_r;
  reg         lowSupply_r;
  reg         fieldLost_r;
  reg         corrErr_r;
  reg         fatalErr_r;
  reg         crcBad_r;
  wire        diagPresent;
  wire        keyAllowed;
  wire        keyWrite;
  wire        regWrite;

  assign diagPresent = fatalErr_r | crcBad_r | lowSupply_r
                     | (fieldLost_r & fieldLossDetEnable);
  assign keyAllowed  = windowOpen | (diagPresent & ~diagOverride_r);
  assign keyWrite    = cmdValid & regRegion & ~cmdIsRead
                     & (cmdAddr == `SCR_ADDR_ENTRY_KEY);
  assign regWrite    = cmdValid & regRegion & ~cmdIsRead & cmdMode_r;

  // Command mode latches until reset only
  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      cmdMode_r <= 1'b0;
    end else if (keyWrite && keyAllowed && cmdData == `SCR_ENTRY_KEY) begin
      cmdMode_r <= 1'b1;
    end
  end

  // Writable control bits; other bits of the written word are dropped
  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      diagOverride_r <= `SCR_RST_DIAG_OVRD;
      cpClock_r      <= `SCR_RST_CP_CLOCK;
      permit_r       <= `SCR_RST_PERMIT;
    end else if (regWrite) begin
      if (cmdAddr == `SCR_ADDR_STATUS_CTRL) begin
        diagOverride_r <= cmdData[`SCR_BIT_DIAG_OVRD];
        cpClock_r      <= cmdData[`SCR_BIT_CP_CLOCK];
      end
      if (cmdAddr == `SCR_ADDR_PERMIT) begin
        permit_r <= cmdData[`SCR_BIT_PERMIT];
      end
    end
  end

  // Monitor flags hold until power-on reset
  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      lowSupply_r <= 1'b0;
      fieldLost_r <= 1'b0;
      corrErr_r   <= 1'b0;
      fatalErr_r  <= 1'b0;
    end else begin
      lowSupply_r <= lowSupply_r | condSync[0];
      fieldLost_r <= fieldLost_r | condSync[1];
      if (memReadDone) begin
        corrErr_r  <= corrErr_r | eccCorrected;
        fatalErr_r <= fatalErr_r | eccFatal;
      end
    end
  end

  // Start-up checksum sequencer over the configuration words
  reg  [3:0]  state_r;
  reg  [3:0]  state_nxt;
  reg  [2:0]  wordIdx_r;
  reg  [7:0]  crcHold_r;
  wire [15:0] rawWord;
  wire [15:0] feedWord;
  wire [7:0]  storedCrc;
  wire        engBusy;
  wire        engDone;
  wire [7:0]  engCrc;
  wire        engInit;
  wire        engStart;

  assign rawWord   = cfgWords[{wordIdx_r, 4'h0} +: 16];
  assign feedWord  = (wordIdx_r == `SCR_CFG_LAST_IDX) ?
                     (rawWord & `SCR_CRC_FIELD_MASK) : rawWord;
  assign storedCrc = cfgWords[119:112];
  assign engInit   = (state_r == ST_INIT);
  assign engStart  = (state_r == ST_FEED);

  scr_crc8 uCrc (
    .clk   (clk),
    .rstN  (rstN),
    .init  (engInit),
    .start (engStart),
    .word  (feedWord),
    .busy  (engBusy),
    .done  (engDone),
    .crc   (engCrc)
  );

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_INIT: state_nxt = ST_FEED;
      ST_FEED: state_nxt = engBusy ? ST_FEED : ST_WAIT;
      ST_WAIT: begin
        if (engDone) begin
          state_nxt = (wordIdx_r == `SCR_CFG_LAST_IDX) ? ST_DONE : ST_FEED;
        end
      end
      ST_DONE: state_nxt = ST_DONE;
      default: state_nxt = ST_INIT;
    endcase
  end

  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      state_r   <= ST_INIT;
      wordIdx_r <= 3'h0;
      crcHold_r <= 8'h00;
      crcBad_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (state_r == ST_WAIT && engDone) begin
        wordIdx_r <= wordIdx_r + 3'h1;
        if (wordIdx_r == `SCR_CFG_LAST_IDX) begin
          crcHold_r <= engCrc;
          crcBad_r  <= (engCrc != storedCrc);
        end
      end
    end
  end

  // Read answers; write-only fields and reserved bits read as zero
  reg         rdValid_r;
  reg  [15:0] rdData_r;
  reg  [15:0] statusWord;

  always @* begin
    statusWord = 16'h0000;
    statusWord[`SCR_BIT_DIAG_PRESENT] = diagPresent;
    statusWord[`SCR_BIT_LOW_SUPPLY]   = lowSupply_r;
    statusWord[`SCR_BIT_CP_CLOCK]     = cpClock_r;
    statusWord[`SCR_BIT_CORR_ERR]     = corrErr_r;
    statusWord[`SCR_BIT_FATAL_ERR]    = fatalErr_r;
    statusWord[`SCR_BIT_FIELD_LOST]   = fieldLost_r;
    statusWord[`SCR_BIT_CRC_BAD]      = crcBad_r;
  end

  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      rdValid_r <= 1'b0;
      rdData_r  <= 16'h0000;
    end else begin
      rdValid_r <= 1'b0;
      if (cmdValid && cmdIsRead && cmdMode_r) begin
        rdValid_r <= 1'b1;
        if (regRegion && cmdAddr == `SCR_ADDR_STATUS_CTRL) begin
          rdData_r <= statusWord;
        end else begin
          rdData_r <= 16'h0000;
        end
      end
    end
  end

  assign rdValid           = rdValid_r;
  assign rdData            = rdData_r;
  assign cmdModeActive     = cmdMode_r;
  assign diagModeActive    = diagPresent & ~diagOverride_r;
  assign chargePumpClockOn = cpClock_r;
  assign programPermit     = permit_r;
  assign crcCheckDone      = (state_r == ST_DONE);
  assign crcValue          = crcHold_r;

endmodule

//--- core/scr_defines.vh
// Constants for the sensor command register bank and its configuration checksum
`ifndef SCR_DEFINES_VH
`define SCR_DEFINES_VH

// Command byte layout
`define SCR_CMD_REGION_HI    7
`define SCR_CMD_REGION_LO    5
`define SCR_CMD_ADDR_HI      4
`define SCR_CMD_ADDR_LO      1
`define SCR_CMD_DIR_BIT      0
`define SCR_REGION_REG       3'h4
`define SCR_DIR_READ         1'b1

// Register addresses inside the 16-bit register region
`define SCR_ADDR_STATUS_CTRL 4'h1
`define SCR_ADDR_ENTRY_KEY   4'ha
`define SCR_ADDR_PERMIT      4'hb

// Unlock key
`define SCR_ENTRY_KEY        16'h16f4

// status_and_control fields
`define SCR_BIT_DIAG_PRESENT 15
`define SCR_BIT_DIAG_OVRD    14
`define SCR_BIT_LOW_SUPPLY   12
`define SCR_BIT_CP_CLOCK     11
`define SCR_BIT_CORR_ERR     8
`define SCR_BIT_FATAL_ERR    7
`define SCR_BIT_FIELD_LOST   6
`define SCR_BIT_CRC_BAD      4

// program_permit_control fields
`define SCR_BIT_PERMIT       11

// Reset values
`define SCR_RST_DIAG_OVRD    1'b0
`define SCR_RST_CP_CLOCK     1'b0
`define SCR_RST_PERMIT       1'b0

// Checksum
`define SCR_CRC_POLY         9'h107
`define SCR_CRC_INIT         8'hff
`define SCR_CRC_MSB_MASK     9'h100
`define SCR_CFG_WORDS        8
`define SCR_CFG_LAST_IDX     3'h7
`define SCR_CFG_FIRST_ADDR   4'h8
`define SCR_CRC_FIELD_MASK   16'hff00
`define SCR_WORD_BITS        5'h10

// Timing
`define SCR_CLK_MHZ          25
`define SCR_ENTRY_WINDOW_US  20000
`define SCR_ENTRY_WINDOW_CYC (`SCR_ENTRY_WINDOW_US * `SCR_CLK_MHZ)

`endif

//--- core/scr_crc8.v
// Bit-serial checksum engine, one data bit per clock, MSB first
`timescale 1ns/1ps
`include "scr_defines.vh"

module scr_crc8 (
  // Clock and reset
  input  wire        clk,
  input  wire        rstN,
  // Control
  input  wire        init,
  input  wire        start,
  input  wire [15:0] word,
  // Result
  output wire        busy,
  output wire        done,
  output wire [7:0]  crc
);

  reg  [7:0]  crc_r;
  reg  [15:0] shift_r;
  reg  [4:0]  cnt_r;
  reg         busy_r;
  reg         done_r;
  reg  [8:0]  step;

  // Shift remainder left, data bit into LSB, fold in polynomial on bit 8
  always @* begin
    step = {crc_r, shift_r[15]};
    if ((step & `SCR_CRC_MSB_MASK) != 9'h000) begin
      step = step ^ `SCR_CRC_POLY;
    end
  end

  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      crc_r   <= `SCR_CRC_INIT;
      shift_r <= 16'h0000;
      cnt_r   <= 5'h00;
      busy_r  <= 1'b0;
      done_r  <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (init && !busy_r) begin
        crc_r <= `SCR_CRC_INIT;
      end else if (start && !busy_r) begin
        shift_r <= word;
        cnt_r   <= `SCR_WORD_BITS;
        busy_r  <= 1'b1;
      end else if (busy_r) begin
        crc_r   <= step[7:0];
        shift_r <= {shift_r[14:0], 1'b0};
        cnt_r   <= cnt_r - 5'h01;
        if (cnt_r == 5'h01) begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
        end
      end
    end
  end

  assign busy = busy_r;
  assign done = done_r;
  assign crc  = crc_r;

endmodule

//--- testbench/scr_master_model.sv
// Behavioural programming master issuing decoded commands
`timescale 1ns/1ps
module scr_master_model (
  input  logic        clk,
  input  logic        rdValid,
  input  logic [15:0] rdData,
  output logic        cmdValid,
  output logic [7:0]  cmdByte,
  output logic [15:0] cmdData
);
  initial begin
    cmdValid = 1'b0;
    cmdByte  = 8'h00;
    cmdData  = 16'h0000;
  end
  // Command byte and its data travel together
  task wr(input [7:0] b, input [15:0] d);
    begin
      @(posedge clk);
      cmdValid <= 1'b1;
      cmdByte  <= b;
      cmdData  <= d;
      @(posedge clk);
      cmdValid <= 1'b0;
      cmdByte  <= ~b;
      cmdData  <= ~d;
      @(posedge clk);
    end
  endtask
  // Read command, answer sampled at the edges after the taking edge
  task rd(input [7:0] b, output [15:0] d, output ok);
    integer i;
    begin
      ok = 1'b0;
      d  = 16'h0000;
      @(posedge clk);
      cmdValid <= 1'b1;
      cmdByte  <= b;
      @(posedge clk);
      cmdValid <= 1'b0;
      cmdByte  <= ~b;
      for (i = 0; i < 3; i = i + 1) begin
        @(posedge clk);
        if (rdValid === 1'b1 && !ok) begin
          ok = 1'b1;
          d  = rdData;
        end
      end
    end
  endtask
endmodule

//--- testbench/scr_command_regs_monitor.sv
// Port assertions for the command register bank
`timescale 1ns/1ps
module scr_command_regs_monitor #(
  parameter ENTRY_WINDOW_CYCLES = 200
) (
  input logic        clk,
  input logic        reset_n,
  input logic        cmdValid,
  input logic [7:0]  cmdByte,
  input logic [15:0] cmdData,
  input logic        rdValid,
  input logic [15:0] rdData,
  input logic        cmdModeActive,
  input logic        diagModeActive,
  input logic        chargePumpClockOn,
  input logic        crcCheckDone,
  input logic [7:0]  crcValue
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_read_answer: assert property (cmdValid && cmdByte == 8'h83 && cmdModeActive |=> rdValid)
    else $error("status read got no answer");
  a_locked_silent: assert property (!cmdModeActive |=> !rdValid)
    else $error("answer while locked");
  a_mode_held: assert property (cmdModeActive |=> cmdModeActive)
    else $error("command mode dropped");
  a_bad_key: assert property (cmdValid && cmdByte == 8'h94 && cmdData != 16'h16f4 && !cmdModeActive
    |=> !cmdModeActive) else $error("wrong key unlocked");
  a_override_hidden: assert property (rdValid |-> !rdData[14])
    else $error("override bit readable");
  a_reserved_zero: assert property (rdValid && $past(cmdByte) == 8'h83 |-> (rdData & 16'h262f) == 16'h0000)
    else $error("reserved status bits set");
  a_permit_hidden: assert property (rdValid && $past(cmdByte) == 8'h97 |-> rdData == 16'h0000)
    else $error("permit register readable");
  a_cp_readback: assert property (rdValid && $past(cmdByte) == 8'h83 |-> rdData[11] == chargePumpClockOn)
    else $error("pump bit mismatch");
  a_diag_report: assert property (rdValid && $past(cmdByte) == 8'h83 && $past(diagModeActive)
    |-> rdData[15]) else $error("diag bit low while diag active");
  a_crc_final: assert property (crcCheckDone |=> crcCheckDone && $stable(crcValue))
    else $error("checksum result changed");
  a_crc_bound: assert property ($rose(reset_n) |-> ##[1:300] crcCheckDone)
    else $error("checksum not finished");
endmodule
bind scr_command_regs scr_command_regs_monitor #(.ENTRY_WINDOW_CYCLES(ENTRY_WINDOW_CYCLES)) uMon (
  .clk(clk), .reset_n(reset_n), .cmdValid(cmdValid), .cmdByte(cmdByte), .cmdData(cmdData),
  .rdValid(rdValid), .rdData(rdData), .cmdModeActive(cmdModeActive), .diagModeActive(diagModeActive),
  .chargePumpClockOn(chargePumpClockOn), .crcCheckDone(crcCheckDone), .crcValue(crcValue));

//--- testbench/scr_command_regs_tb_top.sv
// Self-checking bench for the command register bank
`timescale 1ns/1ps
`include "scr_defines.vh"
module scr_command_regs_tb_top;
  reg           clk = 0, reset_n = 0, lowSupplyIn = 0, fieldLostIn = 0, fieldLossDetEnable = 0;
  reg           memReadDone = 0, eccCorrected = 0, eccFatal = 0;
  reg  [127:0]  cfgWords = 0;
  wire          cmdValid, rdValid, cmdModeActive, diagModeActive, chargePumpClockOn, programPermit, crcCheckDone;
  wire [7:0]    cmdByte, crcValue;
  wire [15:0]   cmdData, rdData;
  integer       errors = 0, cmpCount = 0, i;
  localparam [111:0] LOW7 = 112'h0000_0000_1300_0100_0400_ffc1_0000;
  scr_master_model m (.clk(clk), .rdValid(rdValid), .rdData(rdData),
    .cmdValid(cmdValid), .cmdByte(cmdByte), .cmdData(cmdData));
  scr_command_regs #(.ENTRY_WINDOW_CYCLES(200)) dut (.clk(clk), .reset_n(reset_n), .cmdValid(cmdValid),
    .cmdByte(cmdByte), .cmdData(cmdData), .rdValid(rdValid), .rdData(rdData), .lowSupplyIn(lowSupplyIn),
    .fieldLostIn(fieldLostIn), .fieldLossDetEnable(fieldLossDetEnable), .memReadDone(memReadDone),
    .eccCorrected(eccCorrected), .eccFatal(eccFatal), .cfgWords(cfgWords), .cmdModeActive(cmdModeActive),
    .diagModeActive(diagModeActive), .chargePumpClockOn(chargePumpClockOn), .programPermit(programPermit),
    .crcCheckDone(crcCheckDone), .crcValue(crcValue));
  initial begin
    forever #20 clk = ~clk;
  end
  // Reference checksum; stored byte of the last word taken as zero unless keep is set
  function [7:0] crc8(input [127:0] w, input keep);
    reg [8:0] c;
    integer k, j;
    begin
      c = {1'b0, `SCR_CRC_INIT};
      for (k = 0; k < 8; k = k + 1)
        for (j = 15; j >= 0; j = j - 1) begin
          c = {c[7:0], (k == 7 && j < 8 && !keep) ? 1'b0 : w[16*k+j]};
          if (c[8])
            c = c ^ `SCR_CRC_POLY;
        end
      crc8 = c[7:0];
    end
  endfunction
  task end_of_test;
    begin
      $display("Comparisons %0d mismatches %0d", cmpCount, errors);
      if (errors == 0 && cmpCount > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  task chk(input string n, input [15:0] e, input [15:0] g);
    begin
      cmpCount = cmpCount + 1;
      if (g !== e) begin
        errors = errors + 1;
        $display("ERROR %0s expected %h seen %h", n, e, g);
      end
    end
  endtask
  task rdx(input [7:0] b, input okE, input [15:0] e);
    reg [15:0] d;
    reg        ok;
    begin
      m.rd(b, d, ok);
      chk("answer", {15'h0, okE}, {15'h0, ok});
      if (okE)
        chk("rdData", e, d);
    end
  endtask
  task por(input [15:0] last);
    begin
      @(posedge clk);
      reset_n <= 1'b0;
      lowSupplyIn <= 1'b0;
      fieldLostIn <= 1'b0;
      fieldLossDetEnable <= 1'b0;
      cfgWords <= {last, LOW7};
      repeat (8) @(posedge clk);
      reset_n <= 1'b1;
      for (i = 0; i < 400 && crcCheckDone !== 1'b1; i = i + 1)
        @(posedge clk);
      if (i == 400) begin
        errors = errors + 1;
        $display("ERROR crcCheckDone expected 1 seen %b", crcCheckDone);
        end_of_test;
      end
      chk("crcValue", {8'h00, crc8(cfgWords, 1'b0)}, {8'h00, crcValue});
      chk("crcValue", 16'h00a9, {8'h00, crcValue});
      chk("crcResidue", 16'h0000, {8'h00, crc8({cfgWords[127:120], crcValue, cfgWords[111:0]}, 1'b1)});
    end
  endtask
  task ecc(input c, input f);
    begin
      @(posedge clk);
      memReadDone <= 1'b1;
      eccCorrected <= c;
      eccFatal <= f;
      @(posedge clk);
      memReadDone <= 1'b0;
      eccCorrected <= 1'b0;
      eccFatal <= 1'b0;
      repeat (2) @(posedge clk);
    end
  endtask
  task t_locked;
    begin
      por(16'h00a9);
      rdx(8'h83, 1'b0, 16'h0);
      m.wr(8'h94, 16'h16f5);
      chk("cmdModeActive", 16'h0, {15'h0, cmdModeActive});
      repeat (250) @(posedge clk);
      m.wr(8'h94, `SCR_ENTRY_KEY);
      chk("cmdModeActive", 16'h0, {15'h0, cmdModeActive});
      $display("t_locked done");
    end
  endtask
  task t_enter;
    begin
      por(16'h00a9);
      m.wr(8'h94, `SCR_ENTRY_KEY);
      chk("cmdModeActive", 16'h1, {15'h0, cmdModeActive});
      rdx(8'h83, 1'b1, 16'h0000);
      rdx(8'h11, 1'b1, 16'h0000);
      chk("programPermit", 16'h0, {15'h0, programPermit});
      m.wr(8'h96, 16'hffff);
      chk("programPermit", 16'h1, {15'h0, programPermit});
      rdx(8'h97, 1'b1, 16'h0000);
      chk("chargePumpClockOn", 16'h0, {15'h0, chargePumpClockOn});
      m.wr(8'h82, 16'hffff);
      chk("chargePumpClockOn", 16'h1, {15'h0, chargePumpClockOn});
      rdx(8'h83, 1'b1, 16'h0800);
      repeat (300) @(posedge clk);
      chk("cmdModeActive", 16'h1, {15'h0, cmdModeActive});
      $display("t_enter done");
    end
  endtask
  task t_flags;
    begin
      por(16'h00a9);
      m.wr(8'h94, `SCR_ENTRY_KEY);
      fieldLostIn <= 1'b1;
      repeat (4) @(posedge clk);
      rdx(8'h83, 1'b1, 16'h0040);
      chk("diagModeActive", 16'h0, {15'h0, diagModeActive});
      fieldLossDetEnable <= 1'b1;
      fieldLostIn <= 1'b0;
      repeat (4) @(posedge clk);
      rdx(8'h83, 1'b1, 16'h8040);
      lowSupplyIn <= 1'b1;
      repeat (4) @(posedge clk);
      rdx(8'h83, 1'b1, 16'h9040);
      ecc(1'b1, 1'b0);
      ecc(1'b0, 1'b0);
      rdx(8'h83, 1'b1, 16'h9140);
      ecc(1'b0, 1'b1);
      rdx(8'h83, 1'b1, 16'h91c0);
      chk("diagModeActive", 16'h1, {15'h0, diagModeActive});
      m.wr(8'h82, 16'h4000);
      chk("diagModeActive", 16'h0, {15'h0, diagModeActive});
      rdx(8'h83, 1'b1, 16'h91c0);
      $display("t_flags done");
    end
  endtask
  task t_crcbad;
    begin
      por(16'h00aa);
      chk("diagModeActive", 16'h1, {15'h0, diagModeActive});
      repeat (250) @(posedge clk);
      m.wr(8'h94, `SCR_ENTRY_KEY);
      chk("cmdModeActive", 16'h1, {15'h0, cmdModeActive});
      rdx(8'h83, 1'b1, 16'h8010);
      $display("t_crcbad done");
    end
  endtask
  initial begin
    t_locked;
    t_enter;
    t_flags;
    t_crcbad;
    end_of_test;
  end
endmodule
